// ===== ssr_ctrl.sv
// Stop and restart sequencer that drives a two-wire serial unit from outside.
// Assumes the unit offers a request/acknowledge register port and that the
// bus lines are visible as plain inputs for watching.
`timescale 1ns/1ps
`include "ssr_map.svh"

module ssr_ctrl
#(
  parameter int CLK_PERIOD_NS = `SSR_CLK_PERIOD_NS,
  parameter int TSU_STD_NS    = `SSR_TSU_STA_STD_NS,
  parameter int TSU_FAST_NS   = `SSR_TSU_STA_FAST_NS
)
(
  // Clock and reset.
  input  wire logic                   clock_in,
  input  wire logic                   srst_in,
  // User commands.
  input  wire logic                   cmd_stop_in,
  input  wire logic                   cmd_restart_in,
  input  wire logic                   rx_mode_in,
  input  wire logic                   fast_mode_in,
  input  wire logic [`SSR_BYTE_W-1:0] restart_addr_in,
  // User status.
  output logic                        busy_out,
  output logic                        done_out,
  output logic                        error_out,
  // Register access port of the serial unit.
  output logic                        dev_req_out,
  output logic                        dev_we_out,
  output logic                        dev_sel_out,
  output logic [`SSR_BYTE_W-1:0]      dev_wdata_out,
  input  wire logic                   dev_ack_in,
  input  wire logic [`SSR_BYTE_W-1:0] dev_rdata_in,
  // Bus lines, watched only.
  input  wire logic                   clock_line_pin_in,
  input  wire logic                   data_line_pin_in
);
  import ssr_pkg::*;

  // ========================================================================
  // Derived timing
  // ========================================================================
  // A least time rounds up to whole cycles and never falls below one.
  function automatic logic [`SSR_CNT_W-1:0] ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1)
    begin
      c = 1;
    end
    return c[`SSR_CNT_W-1:0];
  endfunction

  localparam logic [`SSR_CNT_W-1:0] TSU_STD_CYC  = ns_to_cyc(TSU_STD_NS);
  localparam logic [`SSR_CNT_W-1:0] TSU_FAST_CYC = ns_to_cyc(TSU_FAST_NS);

  // ========================================================================
  // Control byte builder
  // ========================================================================
  // Pending is always written as one; every sequence here wants it set.
  function automatic logic [`SSR_BYTE_W-1:0] ctl_byte(input logic msel,
                                                      input logic trx,
                                                      input logic busy);
    logic [`SSR_BYTE_W-1:0] b;
    b                       = '0;
    b[`SSR_BIT_MASTER_SEL]  = msel;
    b[`SSR_BIT_TRX]         = trx;
    b[`SSR_BIT_BUS_BUSY]    = busy;
    b[`SSR_BIT_PIN]  = 1'b1;
    return b;
  endfunction

  // ========================================================================
  // Pin synchroniser
  // ========================================================================
  ssr_pin_if pins ();

  ssr_pin_sync u_sync
  (
    .clock_in   (clock_in),
    .srst_in    (srst_in),
    .scl_raw_in (clock_line_pin_in),
    .sda_raw_in (data_line_pin_in),
    .pins       (pins)
  );

  // ========================================================================
  // Sequencer state
  // ========================================================================
  ssr_main_t st_r;
  ssr_main_t st_nxt;
  logic      access_state;

  // States that hold a register access open on the unit's port.
  always_comb
  begin
    case (st_r.state)
      SSR_STOP_CHK,
      SSR_STOP_WR,
      SSR_RS_WR,
      SSR_RS_BUSY,
      SSR_RS_ADDR,
      SSR_RS_START: access_state = 1'b1;
      SSR_RS_LRB:   access_state = !st_r.rx_mode;
      default:      access_state = 1'b0;
    endcase
  end

  // ========================================================================
  // Next state
  // ========================================================================
  // The gap bit drops the request for one cycle after each acknowledge, so
  // a poll that stays in its state never merges two accesses into one.
  always_comb
  begin
    st_nxt          = st_r;
    st_nxt.done     = 1'b0;
    st_nxt.error    = 1'b0;
    st_nxt.gap      = 1'b0;
    st_nxt.sda_prev = pins.sda_lvl;
    case (st_r.state)
      SSR_IDLE:
      begin
        st_nxt.rx_mode = rx_mode_in;
        st_nxt.fast    = fast_mode_in;
        st_nxt.addr    = restart_addr_in;
        if (cmd_stop_in)
        begin
          // Busy must read one before a stop may be asked for.
          st_nxt.state = SSR_STOP_CHK;
          st_nxt.we    = 1'b0;
          st_nxt.sel   = `SSR_SEL_CTRL;
        end
        else if (cmd_restart_in)
        begin
          st_nxt.state = SSR_RS_WR;
          st_nxt.we    = 1'b1;
          st_nxt.sel   = `SSR_SEL_CTRL;
          st_nxt.wdata = ctl_byte(1'b0, 1'b0, 1'b0);
        end
      end
      SSR_STOP_CHK:
      begin
        if (dev_ack_in)
        begin
          if (dev_rdata_in[`SSR_BIT_BUS_BUSY])
          begin
            st_nxt.state = SSR_STOP_WR;
            st_nxt.we    = 1'b1;
            st_nxt.wdata = ctl_byte(1'b1, 1'b1, 1'b0);
            st_nxt.gap   = 1'b1;
          end
          else
          begin
            // Bus not busy: a stop has nothing to end.
            st_nxt.state = SSR_IDLE;
            st_nxt.we    = 1'b0;
            st_nxt.error = 1'b1;
          end
        end
      end
      SSR_STOP_WR:
      begin
        if (dev_ack_in)
        begin
          st_nxt.state = SSR_STOP_WAIT;
          st_nxt.we    = 1'b0;
        end
      end
      SSR_STOP_WAIT:
      begin
        // No access at all here: the control bits stay as written until
        // the data line rises while the clock line is high.
        if (pins.scl_lvl && pins.sda_lvl && !st_r.sda_prev)
        begin
          st_nxt.state = SSR_IDLE;
          st_nxt.done  = 1'b1;
        end
      end
      SSR_RS_WR:
      begin
        if (dev_ack_in)
        begin
          st_nxt.state = SSR_RS_BUSY;
          st_nxt.we    = 1'b0;
          st_nxt.gap   = 1'b1;
        end
      end
      SSR_RS_BUSY:
      begin
        // The bus still counts as busy to others; only our own busy
        // status is awaited here.
        if (dev_ack_in)
        begin
          st_nxt.gap = 1'b1;
          if (!dev_rdata_in[`SSR_BIT_BUS_BUSY])
          begin
            st_nxt.state = SSR_RS_LRB;
          end
        end
      end
      SSR_RS_LRB:
      begin
        // A receiver has already sent its negative acknowledge, so the
        // last bit says nothing; the clock line itself is watched.
        if (st_r.rx_mode)
        begin
          if (pins.scl_lvl)
          begin
            st_nxt.state = SSR_RS_SETUP;
            st_nxt.cnt   = st_r.fast ? TSU_FAST_CYC : TSU_STD_CYC;
          end
        end
        else if (dev_ack_in)
        begin
          st_nxt.gap = 1'b1;
          if (dev_rdata_in[`SSR_BIT_LRB])
          begin
            st_nxt.state = SSR_RS_SETUP;
            st_nxt.cnt   = st_r.fast ? TSU_FAST_CYC : TSU_STD_CYC;
          end
        end
      end
      SSR_RS_SETUP:
      begin
        // The unit does not time the setup, so this count is the only
        // guard on it.
        if (st_r.cnt <= `SSR_CNT_W'(1))
        begin
          st_nxt.state = SSR_RS_ADDR;
          st_nxt.cnt   = '0;
          st_nxt.we    = 1'b1;
          st_nxt.sel   = `SSR_SEL_DATA;
          st_nxt.wdata = st_r.addr;
        end
        else
        begin
          st_nxt.cnt = st_r.cnt - `SSR_CNT_W'(1);
        end
      end
      SSR_RS_ADDR:
      begin
        if (dev_ack_in)
        begin
          st_nxt.state = SSR_RS_START;
          st_nxt.sel   = `SSR_SEL_CTRL;
          st_nxt.wdata = ctl_byte(1'b1, 1'b1, 1'b1);
          st_nxt.gap   = 1'b1;
        end
      end
      SSR_RS_START:
      begin
        if (dev_ack_in)
        begin
          st_nxt.state = SSR_IDLE;
          st_nxt.we    = 1'b0;
          st_nxt.done  = 1'b1;
        end
      end
      default:
      begin
        st_nxt.state = SSR_IDLE;
      end
    endcase
  end

  // ========================================================================
  // State register
  // ========================================================================
  // The data line reads high at rest, so the edge memory starts high and a
  // spurious stop cannot be seen just after reset.
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      st_r          <= '0;
      st_r.sda_prev <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ========================================================================
  // Outputs
  // ========================================================================
  // The request is a handshake output and may be combinational; its
  // qualifiers all come from registers.
  assign dev_req_out   = access_state && !st_r.gap;
  assign dev_we_out    = st_r.we;
  assign dev_sel_out   = st_r.sel;
  assign dev_wdata_out = st_r.wdata;
  assign busy_out      = (st_r.state != SSR_IDLE);
  assign done_out      = st_r.done;
  assign error_out     = st_r.error;
endmodule

// ===== ssr_ctrl_checker.sv
// Concurrent checks on the ports of the stop and restart sequencer.
// Assumes one clock domain and ssr_map.svh on the include path.
`timescale 1ns/1ps
`include "ssr_map.svh"

module ssr_ctrl_checker
(
  // Clock and reset.
  input wire logic                   clock_in,
  input wire logic                   srst_in,
  // User side.
  input wire logic                   cmd_stop_in,
  input wire logic                   cmd_restart_in,
  input wire logic                   rx_mode_in,
  input wire logic                   fast_mode_in,
  input wire logic [`SSR_BYTE_W-1:0] restart_addr_in,
  input wire logic                   busy_out,
  input wire logic                   done_out,
  input wire logic                   error_out,
  // Register port and watched lines.
  input wire logic                   dev_req_out,
  input wire logic                   dev_we_out,
  input wire logic                   dev_sel_out,
  input wire logic [`SSR_BYTE_W-1:0] dev_wdata_out,
  input wire logic                   dev_ack_in,
  input wire logic [`SSR_BYTE_W-1:0] dev_rdata_in,
  input wire logic                   clock_line_pin_in,
  input wire logic                   data_line_pin_in
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);

  // ========================================================================
  // Register port handshake and command order
  // ========================================================================
  // A request that moves before its acknowledge would be half taken by the unit.
  a_req_held: assert property (dev_req_out && !dev_ack_in |=> dev_req_out && $stable({dev_we_out, dev_sel_out, dev_wdata_out})) else $error("request moved before acknowledge");
  a_req_gap: assert property (dev_req_out && dev_ack_in |=> !dev_req_out) else $error("no gap after acknowledge");
  a_idle_quiet: assert property (!busy_out |-> !dev_req_out) else $error("access while idle");
  a_stop_reads: assert property (!busy_out && cmd_stop_in |=> dev_req_out && !dev_we_out && !dev_sel_out) else $error("stop did not read status first");
  a_restart_word: assert property (!busy_out && cmd_restart_in && !cmd_stop_in |=> dev_req_out && dev_we_out && !dev_sel_out && dev_wdata_out == 8'h10) else $error("wrong restart control word");
  a_stop_quiet: assert property (dev_req_out && dev_ack_in && dev_we_out && !dev_sel_out && dev_wdata_out == 8'hD0 |=> (!dev_req_out) [*8]) else $error("access while stop pending");
  a_start_follows: assert property (dev_req_out && dev_ack_in && dev_we_out && dev_sel_out |=> ##1 dev_req_out && dev_we_out && !dev_sel_out && dev_wdata_out == 8'hF0) else $error("start word missing after address");
  a_done_pulse: assert property (done_out |=> !done_out) else $error("done longer than one cycle");
  a_error_pulse: assert property (error_out |=> !error_out && !done_out) else $error("error longer than one cycle");
endmodule

bind ssr_ctrl ssr_ctrl_checker i_ssr_ctrl_checker (.clock_in, .srst_in, .cmd_stop_in,
  .cmd_restart_in, .rx_mode_in, .fast_mode_in, .restart_addr_in, .busy_out, .done_out,
  .error_out, .dev_req_out, .dev_we_out, .dev_sel_out, .dev_wdata_out, .dev_ack_in,
  .dev_rdata_in, .clock_line_pin_in, .data_line_pin_in);

// ===== ssr_ctrl_note_end.sv
// Closing file of the sequencer sources; it defines nothing of its own.
// Assumes the other sequencer files stand beside it.
`timescale 1ns/1ps

// ===== ssr_ctrl_tb_top.sv
// Self-checking bench: sequencer against the serial unit model.
// Assumes ssr_map.svh on the include path; setup waits are shortened.
`timescale 1ns/1ps
`include "ssr_map.svh"

module ssr_ctrl_tb_top;
  import ssr_pkg::*;
  localparam int M = 4;
  localparam int STD = 5;
  localparam int FAST = 3;
  // Stages of the pin synchroniser in front of the watched clock line.
  localparam int SYNC = 3;
  logic                   clock_in, srst_in, cmd_stop_in, cmd_restart_in, rx_mode_in;
  logic                   fast_mode_in, busy_out, done_out, error_out, dev_req_out;
  logic                   dev_we_out, dev_sel_out, dev_ack_in, clock_line_pin_in;
  logic                   data_line_pin_in, slow_r, hold_r, scl_q, e;
  logic [`SSR_BYTE_W-1:0] restart_addr_in, dev_wdata_out, dev_rdata_in, buf_seen, ctrl_seen;
  int                     errors, compares, cyc, t_rise, t_addr, t_done, t_ack;

  ssr_ctrl #(.TSU_STD_NS(50), .TSU_FAST_NS(30)) i_ssr_ctrl (.clock_in, .srst_in,
    .cmd_stop_in, .cmd_restart_in, .rx_mode_in, .fast_mode_in, .restart_addr_in, .busy_out,
    .done_out, .error_out, .dev_req_out, .dev_we_out, .dev_sel_out, .dev_wdata_out,
    .dev_ack_in, .dev_rdata_in, .clock_line_pin_in, .data_line_pin_in);
  ssr_dev_model #(.M(M), .N(6)) i_ssr_dev_model (.clock_in, .req_in(dev_req_out),
    .we_in(dev_we_out), .sel_in(dev_sel_out), .wdata_in(dev_wdata_out), .ack_out(dev_ack_in),
    .rdata_out(dev_rdata_in), .slow_in(slow_r), .hold_in(hold_r), .scl_out(clock_line_pin_in),
    .sda_out(data_line_pin_in), .buf_out(buf_seen), .ctrl_out(ctrl_seen));

  // ========================================================================
  // Clock and time marks
  // ========================================================================
  initial
  begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  // Marks the last clock line rise, the last read acknowledge and the first
  // address write of a command.
  always @(posedge clock_in)
  begin
    cyc <= cyc + 1;
    scl_q <= clock_line_pin_in;
    if (clock_line_pin_in && !scl_q)
      t_rise <= cyc;
    if (dev_req_out && dev_sel_out && t_addr == 0)
      t_addr <= cyc;
    if (dev_ack_in && !dev_we_out)
      t_ack <= cyc;
  end

  // ========================================================================
  // Tasks
  // ========================================================================
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // One command pulse, then a bounded wait for done or error.
  task automatic run_cmd(input logic stop, input logic rs, input logic rx, input logic fast,
                         input logic [7:0] addr, output logic got_err);
    int i;
    @(posedge clock_in);
    cmd_stop_in <= stop;
    cmd_restart_in <= rs;
    rx_mode_in <= rx;
    fast_mode_in <= fast;
    restart_addr_in <= addr;
    t_addr <= 0;
    @(posedge clock_in);
    cmd_stop_in <= 1'b0;
    cmd_restart_in <= 1'b0;
    for (i = 0; i < 3000 && done_out !== 1'b1 && error_out !== 1'b1; i++)
    begin
      @(posedge clock_in);
      #1;
    end
    if (i == 3000)
    begin
      errors++;
      close_out();
    end
    got_err = error_out;
    t_done = cyc;
  endtask

  // Releases another device's hold on the clock line after the given number of cycles.
  task automatic release_later(input int cycles);
    repeat (cycles) @(posedge clock_in);
    hold_r <= 1'b0;
  endtask

  // ========================================================================
  // Main sequence
  // ========================================================================
  initial
  begin
    {srst_in, slow_r} = 2'b11;
    {cmd_stop_in, cmd_restart_in, rx_mode_in, fast_mode_in, hold_r} = 5'h00;
    {restart_addr_in, errors, compares, cyc, t_rise, t_addr, t_ack} = '0;
    repeat (10) @(posedge clock_in);
    srst_in <= 1'b0;
    // Standard restart with late acknowledges.
    run_cmd(1'b0, 1'b1, 1'b0, 1'b0, 8'hA4, e);
    check(8'(e), 8'h00);
    check(buf_seen, 8'hA4);
    check(ctrl_seen, 8'hF0);
    check(8'(t_addr - t_ack >= STD), 8'h01);
    check(8'(busy_out), 8'h00);
    $display("test restart_standard finished");
    // Fast restart as receiver while another device holds the clock line.
    slow_r <= 1'b0;
    hold_r <= 1'b1;
    fork
      run_cmd(1'b0, 1'b1, 1'b1, 1'b1, 8'h5B, e);
      release_later(40);
    join
    check(buf_seen, 8'h5B);
    check(8'(t_addr - t_rise >= FAST + SYNC), 8'h01);
    $display("test restart_fast_receiver finished");
    // Stop while the clock line is held.
    hold_r <= 1'b1;
    fork
      run_cmd(1'b1, 1'b0, 1'b0, 1'b0, 8'h00, e);
      release_later(30);
    join
    check(8'(e), 8'h00);
    check(ctrl_seen, 8'hD0);
    check(8'(t_done - t_rise >= M), 8'h01);
    check(8'(data_line_pin_in), 8'h01);
    $display("test stop_held_line finished");
    // A second stop finds the bus free and is refused.
    run_cmd(1'b1, 1'b0, 1'b0, 1'b0, 8'h00, e);
    check(8'(e), 8'h01);
    check(ctrl_seen, 8'hD0);
    $display("test stop_bus_free finished");
    close_out();
  end
endmodule

// ===== ssr_dev_model.sv
// Behavioural model of the serial unit: register port, status and bus lines.
// Assumes the controller keeps each request up until acknowledge.
`timescale 1ns/1ps

module ssr_dev_model
#(
  parameter int M = 4,
  parameter int N = 6
)
(
  // Clock and register port.
  input  wire logic       clock_in,
  input  wire logic       req_in,
  input  wire logic       we_in,
  input  wire logic       sel_in,
  input  wire logic [7:0] wdata_in,
  output logic            ack_out,
  output logic [7:0]      rdata_out,
  // Bench controls and observed state.
  input  wire logic       slow_in,
  input  wire logic       hold_in,
  output logic            scl_out,
  output logic            sda_out,
  output logic [7:0]      buf_out,
  output logic [7:0]      ctrl_out
);
  logic busy_r;
  logic scl_drv;

  // ========================================================================
  // Lines and status
  // ========================================================================
  // The clock line is wired-and with another device that may hold it low.
  assign scl_out = scl_drv & !hold_in;
  // The last bit reads the line itself, so a held line reads as zero.
  assign rdata_out = {2'h0, busy_r, 4'h0, scl_out};

  // Accesses are acknowledged at once or three cycles late; line work runs apart.
  initial
  begin
    ack_out = 1'b0;
    // Starts as after a served byte: bus busy and clock held low.
    busy_r = 1'b1;
    scl_drv = 1'b0;
    sda_out = 1'b1;
    buf_out = 8'h00;
    ctrl_out = 8'h00;
    forever
    begin
      @(posedge clock_in);
      ack_out <= 1'b0;
      if (req_in && !ack_out)
      begin
        repeat (slow_in ? 3 : 0) @(posedge clock_in);
        ack_out <= 1'b1;
        if (we_in && sel_in)
          buf_out <= wdata_in;
        if (we_in && !sel_in)
        begin
          ctrl_out <= wdata_in;
          fork
            if (wdata_in == 8'hD0 && busy_r)
            begin
              scl_drv <= 1'b0;
              sda_out <= 1'b0;
              repeat (N) @(posedge clock_in);
              scl_drv <= 1'b1;
              wait (scl_out);
              repeat (M) @(posedge clock_in);
              sda_out <= 1'b1;
              busy_r <= 1'b0;
            end
            else if (wdata_in == 8'h10)
            begin
              sda_out <= 1'b1;
              repeat (N) @(posedge clock_in);
              scl_drv <= 1'b1;
              busy_r <= 1'b0;
            end
            else if (wdata_in == 8'hF0)
            begin
              sda_out <= 1'b0;
              busy_r <= 1'b1;
              repeat (M) @(posedge clock_in);
              scl_drv <= 1'b0;
            end
          join_none
        end
      end
    end
  end
endmodule

// ===== ssr_map.svh
// Named constants for the stop and restart sequencer.
// Assumes the serial unit packs its control and status bits as laid out below.
`ifndef SSR_MAP_SVH
`define SSR_MAP_SVH

// ==========================================================================
// Register selection on the serial unit's access port
// ==========================================================================
`define SSR_SEL_CTRL 1'h0
`define SSR_SEL_DATA 1'h1

// ==========================================================================
// Bit positions in the serial control and status registers
// ==========================================================================
`define SSR_BIT_MASTER_SEL 7
`define SSR_BIT_TRX        6
`define SSR_BIT_BUS_BUSY   5
`define SSR_BIT_PIN 4
`define SSR_BIT_LRB 0

// ==========================================================================
// Restart setup waits in nanoseconds and the local clock period
// ==========================================================================
`define SSR_TSU_STA_STD_NS  4700
`define SSR_TSU_STA_FAST_NS 600
`define SSR_CLK_PERIOD_NS   10

// ==========================================================================
// Widths
// ==========================================================================
`define SSR_CNT_W  16
`define SSR_BYTE_W 8

`endif

// ===== ssr_pin_if.sv
// Carrier for the filtered bus line levels between synchroniser and sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps

interface ssr_pin_if;
  logic scl_lvl;
  logic sda_lvl;

  modport sync (output scl_lvl, output sda_lvl);
  modport user (input scl_lvl, input sda_lvl);
endinterface

// ===== ssr_pin_sync.sv
// Three-stage synchroniser with agreement filter for the two bus lines.
// Assumes the raw lines are asynchronous to clock_in.
`timescale 1ns/1ps

module ssr_pin_sync
(
  // Clock and reset.
  input  wire logic clock_in,
  input  wire logic srst_in,
  // Raw bus lines.
  input  wire logic scl_raw_in,
  input  wire logic sda_raw_in,
  // Filtered levels.
  ssr_pin_if.sync   pins
);
  import ssr_pkg::*;

  ssr_sync_t st_r;
  ssr_sync_t st_nxt;

  // ========================================================================
  // Next state
  // ========================================================================
  // A level is taken only once the second and third stages agree, so a
  // metastable first stage never reaches the output. A phase that stands
  // two cycles is followed, well inside the least widths of an outside driver.
  always_comb
  begin
    st_nxt    = st_r;
    st_nxt.s1 = {scl_raw_in, sda_raw_in};
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < 2; i++)
    begin
      if (st_r.s2[i] == st_r.s3[i])
      begin
        st_nxt.lvl[i] = st_r.s3[i];
      end
    end
  end

  // Idle bus lines are high, so reset to high.
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      st_r <= '1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Level outputs.
  assign pins.scl_lvl = st_r.lvl[1];
  assign pins.sda_lvl = st_r.lvl[0];
endmodule

// ===== ssr_pkg.sv
// Types shared by the stop and restart sequencer modules.
// Assumes ssr_map.svh is on the include path.
`include "ssr_map.svh"

package ssr_pkg;

  // ========================================================================
  // Sequencer states
  // ========================================================================
  typedef enum logic [3:0]
  {
    SSR_IDLE,
    SSR_STOP_CHK,
    SSR_STOP_WR,
    SSR_STOP_WAIT,
    SSR_RS_WR,
    SSR_RS_BUSY,
    SSR_RS_LRB,
    SSR_RS_SETUP,
    SSR_RS_ADDR,
    SSR_RS_START
  } ssr_state_t;

  // ========================================================================
  // Whole state of the sequencer
  // ========================================================================
  typedef struct packed
  {
    ssr_state_t                 state;
    logic                       gap;
    logic                       we;
    logic                       sel;
    logic [`SSR_BYTE_W-1:0]     wdata;
    logic                       rx_mode;
    logic                       fast;
    logic [`SSR_BYTE_W-1:0]     addr;
    logic [`SSR_CNT_W-1:0]      cnt;
    logic                       sda_prev;
    logic                       done;
    logic                       error;
  } ssr_main_t;

  // ========================================================================
  // Whole state of the pin synchroniser
  // ========================================================================
  typedef struct packed
  {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] lvl;
  } ssr_sync_t;

endpackage
